// ### rtl/mms_defines.svh
// constants for the magnetometer mode sequencer: offsets, fields, codes, timing
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MMS_OFF_MODE 8'h00
`define MMS_OFF_STAT1 8'h04
`define MMS_OFF_XDATA 8'h08
`define MMS_OFF_YDATA 8'h0c
`define MMS_OFF_ZDATA 8'h10
`define MMS_OFF_LAST 8'h14
`define MMS_OFF_STAT2 8'h18
`define MMS_OFF_SRST 8'h1c

// ---------------------------------------------------------------
// field positions and mode codes
// ---------------------------------------------------------------
`define MMS_STAT1_READY_BIT 0
`define MMS_STAT1_OVERRUN_BIT 1
`define MMS_STAT2_OVF_BIT 3
`define MMS_SRST_BIT 0
`define MMS_MODE_PD 5'h00
`define MMS_MODE_SINGLE 5'h01
`define MMS_MODE_CONT1 5'h02
`define MMS_MODE_CONT2 5'h04
`define MMS_MODE_CONT3 5'h06
`define MMS_MODE_CONT4 5'h08
`define MMS_MODE_SELFTEST 5'h10
`define MMS_MODE_RESET 5'h00

// ---------------------------------------------------------------
// timing and limits
// ---------------------------------------------------------------
`define MMS_CLK_HZ 125000000
`define MMS_CLK_NS 8
`define MMS_T_MEAS_NS 7200000
`define MMS_RATE1_HZ 10
`define MMS_RATE2_HZ 20
`define MMS_RATE3_HZ 50
`define MMS_RATE4_HZ 100
`define MMS_OVF_UT 4912
`define MMS_SENS_NT_PER_LSB 150

`endif

// ### rtl/mms_pkg.sv
// types shared by the magnetometer mode sequencer
package mms_pkg;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		MMS_ST_PD = 3'b001,
		MMS_ST_MEAS = 3'b010,
		MMS_ST_SLEEP = 3'b100
	} mms_state_t;

	// whole state of the sequencer
	typedef struct packed {
		mms_state_t state;
		logic [4:0] mode;
		logic [31:0] timer;
		logic [31:0] period;
		logic [31:0] period_len;
		logic ready;
		logic overrun;
		logic protect;
		logic ovf;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
		logic [7:0] last;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic selftest;
	} mms_regs_t;

endpackage

// ### rtl/mms_top.sv
// magnetometer mode sequencer with APB register slave
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "mms_defines.svh"

// Summary of operation
// R1: mode code 00000 powers down, 00001 starts single, 10000 starts self-test.
// R2: code 00010 runs periodic at 10 Hz, 00100 at 20 Hz.
// R3: code 00110 runs periodic at 50 Hz, 01000 at 100 Hz.
// R4: after reset the block sits in power-down until another code is written.
// R5: host writes power-down then waits 100 us before any other code.
// R6: registers stay accessible in power-down; values kept until soft reset.
// R7: single end stores axes, mode reads 00000, ready flag set.
// R8: reading data registers or second status starts a read, clearing ready and overrun.
// R9: during measurement data registers keep the previous result.
// R10: periodic modes sleep after storing and wake when the period expires.
// R11: periodic measurement repeats until power-down code is written.
// R12: rewriting a periodic code restarts measurement, keeps status and data.
// R13: from read start until second status read, stored data is frozen.
// R14: host always reads second status after reading data.
// R15: unread result at next completion keeps ready set and sets overrun.
// R16: completion during an open read discards new data and sets overrun.
// R17: periodic completion sets ready flag when entering sleep.
// R18: overflow flag set when |x|+|y|+|z| reaches 4912 uT.
// R19: overflow flag updates together with every axis data update.
// R20: self-test drives internal source, measures, stores, returns to power-down.
// R21: host polls ready after self-test code, then reads axis data.
// R22: single measurement takes 7.2 ms typical, at most 8.2 ms.
// R23: undefined mode codes are ignored and current mode is kept.
module mms_top #(
	parameter int unsigned MEAS_CYC = `MMS_T_MEAS_NS / `MMS_CLK_NS,
	parameter int unsigned PER1_CYC = `MMS_CLK_HZ / `MMS_RATE1_HZ,
	parameter int unsigned PER2_CYC = `MMS_CLK_HZ / `MMS_RATE2_HZ,
	parameter int unsigned PER3_CYC = `MMS_CLK_HZ / `MMS_RATE3_HZ,
	parameter int unsigned PER4_CYC = `MMS_CLK_HZ / `MMS_RATE4_HZ
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// converter results, valid when a measurement ends
	input wire logic [15:0] sample_x_i,
	input wire logic [15:0] sample_y_i,
	input wire logic [15:0] sample_z_i,
	input wire logic [7:0] sample_last_i,
	// front-end control and status
	output logic meas_active_o,
	output logic self_test_drive_o,
	output logic result_ready_o
);
	import mms_pkg::*;

	// ---------------------------------------------------------------
	// constants
	// ---------------------------------------------------------------
	localparam logic [31:0] MEAS_LEN = 32'(MEAS_CYC);
	localparam logic [31:0] OVF_LIMIT = 32'(`MMS_OVF_UT * 1000);
	localparam logic [31:0] SENS = 32'(`MMS_SENS_NT_PER_LSB);

	// reset value of the whole state
	localparam mms_regs_t REGS_RST = '{
		state: MMS_ST_PD,
		mode: `MMS_MODE_RESET,
		timer: 32'h0000_0000,
		period: 32'h0000_0000,
		period_len: 32'h0000_0000,
		ready: 1'b0,
		overrun: 1'b0,
		protect: 1'b0,
		ovf: 1'b0,
		x: 16'h0000,
		y: 16'h0000,
		z: 16'h0000,
		last: 8'h00,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h0000_0000,
		selftest: 1'b0
	};

	mms_regs_t regs_reg;
	mms_regs_t regs_next;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic apb_access;
	logic apb_done;
	logic apb_wr;
	logic apb_rd;
	logic is_periodic_code;
	logic is_start_code;
	logic in_periodic;
	logic rd_data;
	logic rd_stat2;
	logic meas_end;
	logic [31:0] code_period;
	logic [15:0] abs_x;
	logic [15:0] abs_y;
	logic [15:0] abs_z;
	logic [31:0] abs_sum;
	logic ovf_now;

	// one wait state: pready rises on the second access cycle
	assign apb_access = psel_i & penable_i;
	assign apb_done = apb_access & regs_reg.pready;
	assign apb_wr = apb_done & pwrite_i;
	assign apb_rd = apb_done & ~pwrite_i;

	// mode code classification
	assign is_periodic_code = (pwdata_i[4:0] == `MMS_MODE_CONT1) |
		(pwdata_i[4:0] == `MMS_MODE_CONT2) |
		(pwdata_i[4:0] == `MMS_MODE_CONT3) |
		(pwdata_i[4:0] == `MMS_MODE_CONT4); // R2 R3
	assign is_start_code = is_periodic_code |
		(pwdata_i[4:0] == `MMS_MODE_SINGLE) |
		(pwdata_i[4:0] == `MMS_MODE_SELFTEST); // R1
	assign in_periodic = (regs_reg.period_len != 32'h0000_0000);

	// period length picked from the code being written
	always_comb begin
		code_period = 32'h0000_0000;
		case (pwdata_i[4:0])
			`MMS_MODE_CONT1: code_period = 32'(PER1_CYC); // R2
			`MMS_MODE_CONT2: code_period = 32'(PER2_CYC); // R2
			`MMS_MODE_CONT3: code_period = 32'(PER3_CYC); // R3
			`MMS_MODE_CONT4: code_period = 32'(PER4_CYC); // R3
			default: code_period = 32'h0000_0000;
		endcase
	end

	// read-start detection: data registers or second status
	always_comb begin
		rd_data = 1'b0;
		rd_stat2 = 1'b0;
		if (apb_rd && paddr_i == `MMS_OFF_XDATA) begin
			rd_data = 1'b1;
		end else if (apb_rd && paddr_i == `MMS_OFF_YDATA) begin
			rd_data = 1'b1;
		end else if (apb_rd && paddr_i == `MMS_OFF_ZDATA) begin
			rd_data = 1'b1;
		end else if (apb_rd && paddr_i == `MMS_OFF_LAST) begin
			rd_data = 1'b1;
		end else if (apb_rd && paddr_i == `MMS_OFF_STAT2) begin
			rd_stat2 = 1'b1;
		end
	end

	// overflow judgement: sum of magnitudes in nT against the limit
	assign abs_x = sample_x_i[15] ? 16'(-sample_x_i) : sample_x_i;
	assign abs_y = sample_y_i[15] ? 16'(-sample_y_i) : sample_y_i;
	assign abs_z = sample_z_i[15] ? 16'(-sample_z_i) : sample_z_i;
	assign abs_sum = 32'(abs_x) + 32'(abs_y) + 32'(abs_z);
	assign ovf_now = (32'(abs_sum * SENS) >= OVF_LIMIT); // R18

	assign meas_end = (regs_reg.state == MMS_ST_MEAS) && (regs_reg.timer == 32'h0000_0001);

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		regs_next = regs_reg;
		regs_next.pready = apb_access & ~regs_reg.pready;
		regs_next.pslverr = 1'b0;

		// free-running interval counter, runs through sleep
		if (regs_reg.period != 32'h0000_0000) begin
			regs_next.period = regs_reg.period - 32'h0000_0001;
		end

		// sequencer
		case (regs_reg.state)
			MMS_ST_PD: begin
				regs_next.selftest = 1'b0;
			end
			MMS_ST_MEAS: begin
				regs_next.timer = regs_reg.timer - 32'h0000_0001;
				if (meas_end) begin
					if (in_periodic) begin
						regs_next.state = MMS_ST_SLEEP; // R10
					end else begin
						regs_next.state = MMS_ST_PD; // R7 R20
						regs_next.mode = `MMS_MODE_PD; // R7
						regs_next.selftest = 1'b0;
					end
				end
			end
			MMS_ST_SLEEP: begin
				// wake when the interval counter expires
				if (regs_reg.period == 32'h0000_0001) begin
					regs_next.state = MMS_ST_MEAS; // R10 R11
					regs_next.timer = MEAS_LEN;
					regs_next.period = regs_reg.period_len;
				end
			end
			default: begin
				regs_next.state = MMS_ST_PD;
			end
		endcase

		// read start clears the flags; a completion below still wins
		if (rd_data || rd_stat2) begin
			regs_next.ready = 1'b0; // R8
			regs_next.overrun = 1'b0; // R8
		end
		if (rd_data) begin
			regs_next.protect = 1'b1; // R13
		end
		if (rd_stat2) begin
			regs_next.protect = 1'b0; // R13
		end

		// completion: store or discard; data untouched while measuring
		if (meas_end) begin
			if (regs_reg.protect) begin
				regs_next.overrun = 1'b1; // R16
			end else begin
				regs_next.x = sample_x_i; // R7 R9
				regs_next.y = sample_y_i;
				regs_next.z = sample_z_i;
				regs_next.last = sample_last_i;
				regs_next.ovf = ovf_now; // R19
				regs_next.ready = 1'b1; // R7 R17
				if (regs_reg.ready) begin
					regs_next.overrun = 1'b1; // R15
				end
			end
		end

		// register writes
		if (apb_wr) begin
			if (paddr_i == `MMS_OFF_MODE) begin
				if (pwdata_i[4:0] == `MMS_MODE_PD) begin
					// power-down ends any mode, flags and data kept
					regs_next.state = MMS_ST_PD; // R1 R11
					regs_next.mode = `MMS_MODE_PD;
					regs_next.period = 32'h0000_0000;
					regs_next.period_len = 32'h0000_0000;
					regs_next.selftest = 1'b0;
				end else if (is_start_code && regs_reg.state == MMS_ST_PD) begin
					// the 100 us settle after power-down is left to the host
					regs_next.state = MMS_ST_MEAS; // R1 R5
					regs_next.mode = pwdata_i[4:0];
					regs_next.timer = MEAS_LEN; // R22
					regs_next.period = code_period;
					regs_next.period_len = code_period;
					regs_next.selftest = (pwdata_i[4:0] == `MMS_MODE_SELFTEST); // R20
				end else if (is_periodic_code && in_periodic) begin
					// restart without touching status or data
					regs_next.state = MMS_ST_MEAS; // R12
					regs_next.mode = pwdata_i[4:0];
					regs_next.timer = MEAS_LEN;
					regs_next.period = code_period;
					regs_next.period_len = code_period;
				end
				// any other code is dropped and the mode stands: R23
			end else if (paddr_i == `MMS_OFF_SRST) begin
				if (pwdata_i[`MMS_SRST_BIT]) begin
					regs_next = REGS_RST; // R6
					regs_next.pready = 1'b0;
				end
			end else if (paddr_i == `MMS_OFF_STAT1 || paddr_i == `MMS_OFF_XDATA ||
				paddr_i == `MMS_OFF_YDATA || paddr_i == `MMS_OFF_ZDATA ||
				paddr_i == `MMS_OFF_LAST || paddr_i == `MMS_OFF_STAT2) begin
				// read-only, write ignored
				regs_next.pslverr = 1'b0;
			end else begin
				regs_next.pslverr = 1'b0;
			end
		end

		// read data and error answer, prepared for the pready cycle
		regs_next.prdata = 32'h0000_0000;
		if (apb_access && !regs_reg.pready) begin
			if (paddr_i == `MMS_OFF_MODE) begin
				regs_next.prdata = {27'h0, regs_reg.mode}; // R6
			end else if (paddr_i == `MMS_OFF_STAT1) begin
				regs_next.prdata[`MMS_STAT1_READY_BIT] = regs_reg.ready;
				regs_next.prdata[`MMS_STAT1_OVERRUN_BIT] = regs_reg.overrun;
			end else if (paddr_i == `MMS_OFF_XDATA) begin
				regs_next.prdata = {16'h0000, regs_reg.x}; // R9
			end else if (paddr_i == `MMS_OFF_YDATA) begin
				regs_next.prdata = {16'h0000, regs_reg.y};
			end else if (paddr_i == `MMS_OFF_ZDATA) begin
				regs_next.prdata = {16'h0000, regs_reg.z};
			end else if (paddr_i == `MMS_OFF_LAST) begin
				regs_next.prdata = {24'h000000, regs_reg.last};
			end else if (paddr_i == `MMS_OFF_STAT2) begin
				regs_next.prdata[`MMS_STAT2_OVF_BIT] = regs_reg.ovf;
			end else if (paddr_i == `MMS_OFF_SRST) begin
				regs_next.prdata = 32'h0000_0000;
			end else begin
				regs_next.pslverr = 1'b1; // unmapped
			end
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			regs_reg <= REGS_RST; // R4
		end else begin
			regs_reg <= regs_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from flops
	// ---------------------------------------------------------------
	assign prdata_o = regs_reg.prdata;
	assign pready_o = regs_reg.pready;
	assign pslverr_o = regs_reg.pslverr;
	assign meas_active_o = regs_reg.state[1];
	assign self_test_drive_o = regs_reg.selftest;
	assign result_ready_o = regs_reg.ready;

endmodule // mms_top

// ### sim/mms_top_monitor.sv
// assertion checker watching the mode sequencer ports
`timescale 1ns/10ps
module mms_top_monitor #(
	parameter int unsigned MEAS_CYC = 900000
) (
	// clock, reset and apb
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// front-end side
	input wire logic meas_active_o,
	input wire logic self_test_drive_o,
	input wire logic result_ready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [31:0] meas_cnt_reg;
	logic mode_wr;
	logic data_rd;
	// a periodic code rewritten while periodic restarts the measurement, so any mode write restarts the count
	assign mode_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00;
	assign data_rd = psel_i && penable_i && pready_o && !pwrite_i && paddr_i >= 8'h08;
	// length of the running measurement
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			meas_cnt_reg <= 32'h0;
		else if (!meas_active_o || mode_wr)
			meas_cnt_reg <= 32'h0;
		else
			meas_cnt_reg <= meas_cnt_reg + 32'h1;
	end
	property p_ready_pulse; pready_o |=> !pready_o; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_one_wait; $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o; endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
	property p_err_ready; pslverr_o |-> pready_o; endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_rdata_idle; !pready_o |-> prdata_o == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	// unmapped: beyond the last word or not word aligned
	property p_unmapped;
		pready_o && !pwrite_i |-> pslverr_o == (paddr_i > 8'h1c || paddr_i[1:0] != 2'b00);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("wrong error answer");
	property p_meas_len; meas_cnt_reg <= MEAS_CYC; endproperty
	a_meas_len: assert property (p_meas_len) else $error("measurement too long");
	property p_selftest; self_test_drive_o |-> meas_active_o; endproperty
	a_selftest: assert property (p_selftest) else $error("source driven outside measure");
	property p_read_clears; data_rd && paddr_i <= 8'h18 |=> !result_ready_o || $fell(meas_active_o);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("ready kept after read");
	property p_ready_cause; $rose(result_ready_o) |-> $fell(meas_active_o); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without completion");
	// main scenarios
	c_meas_end: cover property ($fell(meas_active_o));
	c_selftest: cover property (self_test_drive_o);
	c_slverr: cover property (pslverr_o);
endmodule // mms_top_monitor

bind mms_top mms_top_monitor #(.MEAS_CYC(MEAS_CYC)) u_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.meas_active_o(meas_active_o), .self_test_drive_o(self_test_drive_o),
	.result_ready_o(result_ready_o));

// ### sim/mms_front_model.sv
// converter front-end model feeding results to the sequencer
`timescale 1ns/10ps
module mms_front_model (
	// control from the sequencer
	input wire logic meas_active_i,
	// values the next measurement yields
	input wire logic [15:0] x_i,
	input wire logic [15:0] y_i,
	input wire logic [15:0] z_i,
	input wire logic [7:0] last_i,
	// results towards the sequencer
	output logic [15:0] x_o,
	output logic [15:0] y_o,
	output logic [15:0] z_o,
	output logic [7:0] last_o
);
	// results are only valid while measuring; the inverse elsewhere
	// exposes a sequencer that samples at the wrong moment
	assign x_o = meas_active_i ? x_i : ~x_i;
	assign y_o = meas_active_i ? y_i : ~y_i;
	assign z_o = meas_active_i ? z_i : ~z_i;
	assign last_o = meas_active_i ? last_i : ~last_i;
endmodule // mms_front_model

// ### sim/magnetometer_mode_sequencer_test.sv
// self-checking bench for the magnetometer mode sequencer
`timescale 1ns/10ps
`include "mms_defines.svh"
module magnetometer_mode_sequencer_test;
	localparam int unsigned T_WAIT = 200; // power-down settle, scaled down to keep runs short
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, meas, stdrv, rdy, e;
	logic [15:0] vx = 16'h0, vy = 16'h0, vz = 16'h0, sx, sy, sz;
	logic [7:0] vl = 8'h00, sl;
	int mismatches = 0;
	int checks_done = 0;
	int c;
	int unsigned per [4] = '{100, 80, 60, 40};
	logic [4:0] code [4] = '{`MMS_MODE_CONT1, `MMS_MODE_CONT2, `MMS_MODE_CONT3, `MMS_MODE_CONT4};

	always #4 clk_i = ~clk_i;

	mms_top #(.MEAS_CYC(20), .PER1_CYC(100), .PER2_CYC(80), .PER3_CYC(60), .PER4_CYC(40)) u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .sample_x_i(sx), .sample_y_i(sy),
		.sample_z_i(sz), .sample_last_i(sl), .meas_active_o(meas),
		.self_test_drive_o(stdrv), .result_ready_o(rdy));
	mms_front_model u_front (.meas_active_i(meas), .x_i(vx), .y_i(vy), .z_i(vz), .last_i(vl),
		.x_o(sx), .y_o(sy), .z_o(sz), .last_o(sl));

	// ---------------------------------------------------------------
	// bus and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	// one apb transfer; pready is looked at on the falling edge, where it has settled,
	// and the request stands through the rising edge that samples it high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(negedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			finish_test();
		end
		r = prdata;
		e = pslverr;
		@(posedge clk_i);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, r, x);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// poll the first status until ready, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			apb(1'b0, `MMS_OFF_STAT1, 32'h0);
			n++;
		end while (r[0] !== 1'b1 && n < 100);
	endtask
	task automatic wl(input logic v);
		// level looked at on falling edges; back on a rising edge before any bus use
		do begin
			@(negedge clk_i);
			c++;
		end while (meas !== v && c < 2000);
		@(posedge clk_i);
	endtask
	task automatic pd();
		wr(`MMS_OFF_MODE, {27'h0, `MMS_MODE_PD});
		repeat (T_WAIT) @(posedge clk_i);
	endtask
	function automatic int ab(input logic [15:0] v);
		return v[15] ? 65536 - int'(v) : int'(v);
	endfunction
	function automatic logic [31:0] ovf(input logic [15:0] x, input logic [15:0] y,
		input logic [15:0] z);
		return (ab(x) + ab(y) + ab(z)) * `MMS_SENS_NT_PER_LSB >= `MMS_OVF_UT * 1000 ? 32'h8 : 32'h0;
	endfunction
	// one single or self-test measurement followed by a full read
	task automatic shot(input logic [4:0] m, input logic [15:0] x, input logic [15:0] y,
		input logic [15:0] z, input logic [7:0] l);
		vx <= x;
		vy <= y;
		vz <= z;
		vl <= l;
		wr(`MMS_OFF_MODE, {27'h0, m});
		chk("self test drive", {31'h0, stdrv}, {31'h0, m == `MMS_MODE_SELFTEST});
		wait_rdy();
		chk("ready pin", {31'h0, rdy}, 32'h1);
		rd(`MMS_OFF_MODE, 32'h0, "mode");
		rd(`MMS_OFF_XDATA, {16'h0, x}, "x");
		rd(`MMS_OFF_YDATA, {16'h0, y}, "y");
		rd(`MMS_OFF_ZDATA, {16'h0, z}, "z");
		rd(`MMS_OFF_LAST, {24'h0, l}, "last");
		rd(`MMS_OFF_STAT2, ovf(x, y, z), "stat2");
		chk("ready pin", {31'h0, rdy}, 32'h0);
		rd(`MMS_OFF_STAT1, 32'h0, "stat1");
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(`MMS_OFF_MODE, 32'h0, "mode");
		rd(`MMS_OFF_STAT1, 32'h0, "stat1");
		wr(`MMS_OFF_MODE, 32'h3);
		rd(`MMS_OFF_MODE, 32'h0, "mode");
		chk("busy", {31'h0, meas}, 32'h0);
		shot(`MMS_MODE_SINGLE, 16'h1234, 16'hfedc, 16'h0042, 8'h5a);
		shot(`MMS_MODE_SINGLE, 16'd32746, 16'h0, 16'h0, 8'h01);
		shot(`MMS_MODE_SINGLE, 16'd32747, 16'h0, 16'h0, 8'h02);
		shot(`MMS_MODE_SELFTEST, 16'hffff, 16'h8002, 16'h0, 8'h03);
		// a read opened during measurement keeps the old result
		vx <= 16'h0777;
		wr(`MMS_OFF_MODE, {27'h0, `MMS_MODE_SINGLE});
		rd(`MMS_OFF_XDATA, 32'hffff, "x old");
		c = 0;
		wl(1'b0);
		rd(`MMS_OFF_STAT1, 32'h2, "stat1");
		rd(`MMS_OFF_XDATA, 32'hffff, "x kept");
		rd(`MMS_OFF_STAT2, 32'h8, "stat2");
		rd(`MMS_OFF_STAT1, 32'h0, "stat1");
		for (int i = 0; i < 4; i++) begin
			vx <= 16'h0100 + 16'(i);
			vy <= 16'h0;
			vz <= 16'h0;
			wr(`MMS_OFF_MODE, {27'h0, code[i]});
			c = 0;
			wl(1'b0);
			wl(1'b1);
			c = 0;
			wl(1'b0);
			wl(1'b1);
			chk("period", 32'(c), per[i]);
			wr(`MMS_OFF_MODE, {27'h0, code[i]});
			rd(`MMS_OFF_STAT1, 32'h3, "stat1");
			rd(`MMS_OFF_XDATA, 32'h0100 + i, "x");
			rd(`MMS_OFF_STAT2, 32'h0, "stat2");
			pd();
			chk("busy", {31'h0, meas}, 32'h0);
		end
		rd(`MMS_OFF_XDATA, 32'h0103, "x pd");
		wr(`MMS_OFF_SRST, 32'h1);
		rd(`MMS_OFF_XDATA, 32'h0, "x srst");
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", {31'h0, e}, 32'h1);
		chk("rdata", r, 32'h0);
		finish_test();
	end

	// watchdog, well beyond the few thousand cycles the tests take
	initial begin
		#400000;
		mismatches++;
		finish_test();
	end
endmodule // magnetometer_mode_sequencer_test
